// ### src/imc_pkg.sv
/*
 holds the offsets, field positions, reset values and enumerations of the integration
 mode control block. assumes a 32-bit register bus with byte addresses.
*/
package imc_pkg;
   // register byte offsets
   localparam logic [7:0] IMC_OFF_CTRL = 8'h00;    // integration_control_reg
   localparam logic [7:0] IMC_OFF_INDEX = 8'h04;   // test_output_index_reg
   localparam logic [7:0] IMC_OFF_STATUS = 8'h08;  // ram test status
   localparam logic [7:0] IMC_OFF_RDATA = 8'h0c;   // ram read data
   localparam logic [7:0] IMC_OFF_WDATA = 8'h10;   // ram write data
   // control field positions
   localparam int IMC_BIT_INTEG = 0;
   localparam int IMC_BIT_DRIVE = 1;
   localparam int IMC_BIT_WNR = 2;
   localparam int IMC_BIT_TARGET = 3;
   localparam int IMC_ACC_LSB = 4;
   localparam int IMC_ACC_MSB = 8;
   localparam int IMC_CTRL_MSB = 8;
   // reset values
   localparam logic [8:0] IMC_CTRL_RESET = 9'h000;
   localparam logic [31:0] IMC_WORD_RESET = 32'h0000_0000;
   // translation buffer unit count and its index width
   localparam int IMC_TBU_COUNT = 8;
   localparam int IMC_TBU_BITS = $clog2(IMC_TBU_COUNT);
   // walk control unit ram codes on the low access bit(s)
   typedef enum logic [1:0] {
      IMC_RAM_IPA = 2'b00,  // intermediate_to_physical_ram
      IMC_RAM_MWC = 2'b01,  // macro_walk_cache_ram
      IMC_RAM_DFIFO = 2'b10 // descriptor_fifo_ram
   } imc_wcu_ram_t;
   // ram access sequencer states
   typedef enum logic [1:0] {
      IMC_ST_IDLE = 2'b00,
      IMC_ST_REQ = 2'b01,
      IMC_ST_DONE = 2'b10
   } imc_state_t;
endpackage

// ### src/imc_ram_if.sv
/*
 carries one ram test access from the register block to the ram port module.
 assumes both ends share sys_clk.
*/
`timescale 1ns/1ps
interface imc_ram_if;
   logic start;         // one-cycle pulse: begin an access
   logic wnr;           // 1 write, 0 read
   logic target;        // 0 walk control unit, 1 translation buffer unit
   logic [1:0] wcu_sel; // walk control unit ram code
   logic [2:0] tbu_sel; // translation buffer unit number
   logic [31:0] index;  // ram location
   logic [31:0] wdata;  // write data
   logic done;          // one-cycle pulse: access finished
   logic [31:0] rdata;  // read data captured at done
   modport ctrl (output start, wnr, target, wcu_sel, tbu_sel, index, wdata, input done, rdata);
   modport port (input start, wnr, target, wcu_sel, tbu_sel, index, wdata, output done, rdata);
endinterface

// ### src/imc_ram_port.sv
/*
 drives the shared ram test bus for one access and returns the result.
 assumes the ram answers with ram_ack while ram_req is held.
*/
`timescale 1ns/1ps
module imc_ram_port
   import imc_pkg::*;
(
   input wire logic sys_clk,      // clock
   input wire logic rst,          // synchronous reset
   imc_ram_if.port bus,           // request from register block
   output logic ram_req,          // ram bus request
   output logic ram_we,           // ram write enable
   output logic ram_target,       // 0 walk unit, 1 buffer unit
   output logic [2:0] ram_select, // ram or buffer unit number
   output logic [31:0] ram_addr,  // ram index
   output logic [31:0] ram_wdata, // ram write data
   input wire logic ram_ack,      // ram finished
   input wire logic [31:0] ram_rdata // ram read data
);
   typedef struct packed {
      imc_state_t st;
      logic we;
      logic target;
      logic [2:0] sel;
      logic [31:0] addr;
      logic [31:0] wdata;
      logic [31:0] rdata;
   } imc_port_t;
   imc_port_t cur, next_cur;

   // sequencer: latch request, hold bus until ack, capture read data
   always_comb begin
      next_cur = cur;
      case (cur.st)
         IMC_ST_IDLE: begin
            if (bus.start) begin
               next_cur.st = IMC_ST_REQ;
               next_cur.we = bus.wnr;
               next_cur.target = bus.target;
               next_cur.sel = bus.target ? bus.tbu_sel : {1'b0, bus.wcu_sel};
               next_cur.addr = bus.index;
               next_cur.wdata = bus.wdata;
            end
         end
         IMC_ST_REQ: begin
            if (ram_ack) begin
               next_cur.st = IMC_ST_DONE;
               if (!cur.we) begin
                  next_cur.rdata = ram_rdata;
               end
            end
         end
         default: next_cur.st = IMC_ST_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   assign ram_req = (cur.st == IMC_ST_REQ);
   assign ram_we = cur.we;
   assign ram_target = cur.target;
   assign ram_select = cur.sel;
   assign ram_addr = cur.addr;
   assign ram_wdata = cur.wdata;
   assign bus.done = (cur.st == IMC_ST_DONE);
   assign bus.rdata = cur.rdata;
endmodule // imc_ram_port

// ### src/imc_top.sv
/*
 integration mode control register block with ram test access, as an avalon-mm slave.
 assumes synchronous pins, one 100 mhz clock and a synchronous active-high reset.
*/
// Local design decisions: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
module imc_top
   import imc_pkg::*;
(
   input wire logic sys_clk,               // clock
   input wire logic rst,                   // synchronous reset, high
   input wire logic [7:0] avs_address,     // byte address
   input wire logic avs_read,              // read request
   input wire logic avs_write,             // write request
   input wire logic [31:0] avs_writedata,  // write data
   input wire logic [3:0] avs_byteenable,  // byte lanes
   input wire logic avs_secure,            // access is secure
   output logic [31:0] avs_readdata,       // read data
   output logic avs_waitrequest,           // stall
   output logic [1:0] avs_response,        // 00 ok, 10 slave error
   input wire logic integ_sec_override,    // admits non-secure access
   input wire logic [31:0] func_out,       // functional output values
   output logic [31:0] dev_out,            // device outputs
   input wire logic [31:0] dev_in,         // device inputs
   output logic [31:0] func_in,            // inputs seen by functional logic
   output logic integ_mode,                // integration mode active
   output logic ram_req,                   // ram bus request
   output logic ram_we,                    // ram write enable
   output logic ram_target,                // 0 walk unit, 1 buffer unit
   output logic [2:0] ram_select,          // ram code or unit number
   output logic [31:0] ram_addr,           // ram index
   output logic [31:0] ram_wdata,          // ram write data
   input wire logic ram_ack,               // ram finished
   input wire logic [31:0] ram_rdata       // ram read data
);
   typedef struct packed {
      logic [IMC_CTRL_MSB:0] ctrl;
      logic [31:0] index;
      logic [31:0] wdata;
      logic [31:0] rdata;
      logic [31:0] out_val;
      logic busy;
      logic ack;
      logic err;
      logic [31:0] rd;
   } imc_regs_t;
   imc_regs_t r, next_r;

   imc_ram_if rif ();
   logic req;
   logic allowed;
   logic [31:0] wmask;
   logic [31:0] ctrl_word;
   logic start;

   imc_ram_port u_port (
      .sys_clk(sys_clk),
      .rst(rst),
      .bus(rif),
      .ram_req(ram_req),
      .ram_we(ram_we),
      .ram_target(ram_target),
      .ram_select(ram_select),
      .ram_addr(ram_addr),
      .ram_wdata(ram_wdata),
      .ram_ack(ram_ack),
      .ram_rdata(ram_rdata)
   );

   // access filter and byte-lane mask
   assign req = (avs_read || avs_write) && !r.ack;
   assign allowed = avs_secure || integ_sec_override;
   assign ctrl_word = {23'h000000, r.ctrl};
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         wmask[i*8 +: 8] = {8{avs_byteenable[i]}};
      end
   end

   // a ram access starts when drive is set, in integration mode, no access is busy, and the index is written by an admitted access
   assign start = req && avs_write && allowed && (avs_address == IMC_OFF_INDEX) && !r.busy
      && r.ctrl[IMC_BIT_INTEG] && r.ctrl[IMC_BIT_DRIVE];

   assign rif.start = start;
   assign rif.wnr = r.ctrl[IMC_BIT_WNR];
   assign rif.target = r.ctrl[IMC_BIT_TARGET];
   assign rif.wcu_sel = {1'b0, r.ctrl[IMC_ACC_LSB]};
   assign rif.tbu_sel = r.ctrl[IMC_ACC_LSB +: IMC_TBU_BITS];
   assign rif.index = (avs_writedata & wmask) | (r.index & ~wmask);
   assign rif.wdata = r.wdata;

   // register file: one-cycle answer via ack, refused accesses answer with error
   always_comb begin
      next_r = r;
      next_r.ack = 1'b0;
      next_r.err = 1'b0;
      next_r.rd = IMC_WORD_RESET;
      if (rif.done) begin
         next_r.busy = 1'b0;
         next_r.rdata = rif.rdata;
      end
      if (start) begin
         next_r.busy = 1'b1;
      end
      if (req) begin
         next_r.ack = 1'b1;
         if (!allowed) begin
            next_r.err = 1'b1;
         end else if (avs_address == IMC_OFF_CTRL) begin
            next_r.rd = ctrl_word;
            if (avs_write) begin
               // software keeps writes to the disabled state; no check here
               next_r.ctrl = (avs_writedata[IMC_CTRL_MSB:0] & wmask[IMC_CTRL_MSB:0])
                  | (r.ctrl & ~wmask[IMC_CTRL_MSB:0]);
            end
         end else if (avs_address == IMC_OFF_INDEX) begin
            next_r.rd = r.index;
            if (avs_write) begin
               next_r.index = rif.index;
            end
         end else if (avs_address == IMC_OFF_STATUS) begin
            next_r.rd = {31'h00000000, r.busy};
         end else if (avs_address == IMC_OFF_RDATA) begin
            next_r.rd = r.rdata;
            if (avs_write) begin
               // direct output value only from admitted accesses
               next_r.out_val = (avs_writedata & wmask) | (r.out_val & ~wmask);
            end
         end else if (avs_address == IMC_OFF_WDATA) begin
            next_r.rd = r.wdata;
            if (avs_write) begin
               next_r.wdata = (avs_writedata & wmask) | (r.wdata & ~wmask);
            end
         end else begin
            next_r.err = 1'b1; // unmapped
         end
      end
   end

   // state register
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   // bus answers
   assign avs_waitrequest = (avs_read || avs_write) && !r.ack;
   assign avs_readdata = r.rd;
   assign avs_response = r.err ? 2'b10 : 2'b00;

   // pin steering in integration mode; rdata offset doubles as direct output value on write
   assign integ_mode = r.ctrl[IMC_BIT_INTEG];
   assign dev_out = integ_mode ? r.out_val : func_out;
   assign func_in = integ_mode ? IMC_WORD_RESET : dev_in;

   // checks
   a_reset_ctrl: assert property (@(posedge sys_clk) rst |=> (r.ctrl == IMC_CTRL_RESET))
      else $error("control not cleared by reset");
   a_nonsec_refused: assert property (@(posedge sys_clk) disable iff (rst)
      req && !avs_secure && !integ_sec_override |=> avs_response == 2'b10 && $stable(r.ctrl))
      else $error("non-secure access not refused");
   a_pins_steered: assert property (@(posedge sys_clk) disable iff (rst)
      integ_mode |-> dev_out == r.out_val)
      else $error("outputs not under register control");
   a_no_drive: assert property (@(posedge sys_clk) disable iff (rst)
      !r.ctrl[IMC_BIT_DRIVE] && !r.busy |-> !start)
      else $error("ram access without drive");
   a_dir_write: assert property (@(posedge sys_clk) disable iff (rst)
      start |=> ram_req && ram_we == $past(r.ctrl[IMC_BIT_WNR]))
      else $error("ram direction wrong");
   a_target_sel: assert property (@(posedge sys_clk) disable iff (rst)
      start |=> ram_target == $past(r.ctrl[IMC_BIT_TARGET]))
      else $error("ram target wrong");
   a_wcu_code: assert property (@(posedge sys_clk) disable iff (rst)
      start && !r.ctrl[IMC_BIT_TARGET] |=> ram_select[2:1] == 2'b00)
      else $error("walk unit code uses ignored bits");
   a_reserved_zero: assert property (@(posedge sys_clk) disable iff (rst)
      r.ack && !r.err && $past(avs_address) == IMC_OFF_CTRL |-> avs_readdata[31:9] == 23'h000000)
      else $error("reserved bits not zero");
endmodule // imc_top

// ### test/tb_imc_top.sv
/*
 self-checking bench for imc_top: reset values, security filter, integration pins and ram test accesses.
 assumes the imc_pkg register map and a bus answer that comes after at least one wait state.
*/
`timescale 1ns/1ps
module tb_imc_top;
   import imc_pkg::*;
   logic sys_clk, rst, avs_read, avs_write, avs_secure, integ_sec_override, ram_ack;
   logic avs_waitrequest, integ_mode, ram_req, ram_we, ram_target;
   logic [7:0] avs_address;
   logic [3:0] avs_byteenable;
   logic [1:0] avs_response, r;
   logic [2:0] ram_select;
   logic [31:0] avs_writedata, func_out, dev_in, ram_rdata, avs_readdata, dev_out, func_in, ram_addr, ram_wdata, q;
   int failures, n_tests;

   imc_top imc_top_i (.sys_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
      .avs_secure, .avs_readdata, .avs_waitrequest, .avs_response, .integ_sec_override, .func_out, .dev_out,
      .dev_in, .func_in, .integ_mode, .ram_req, .ram_we, .ram_target, .ram_select, .ram_addr, .ram_wdata,
      .ram_ack, .ram_rdata);

   // free-running 100 mhz clock
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one bus cycle; entered just after a rising edge, holds the request until waitrequest is seen low
   // at a rising edge, takes the answer at that edge, then lets one idle edge pass
   task bus(input logic [7:0] a, input logic w, input logic [31:0] d, input logic s);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= d;
      avs_secure <= s;
      do begin
         @(posedge sys_clk);
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      r = avs_response;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge sys_clk);
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      bus(a, 1'b1, d, 1'b1);
   endtask

   task rd(input logic [7:0] a);
      bus(a, 1'b0, 32'h0, 1'b1);
   endtask

   task t_reset;
      rd(IMC_OFF_CTRL);
      chk(q, 32'h0);
      chk(32'(integ_mode), 32'h0);
      chk(32'(ram_req), 32'h0);
      wr(IMC_OFF_CTRL, 32'hffff_fff8);
      rd(IMC_OFF_CTRL);
      chk(q, 32'h0000_01f8);
      wr(IMC_OFF_CTRL, 32'h0);
   endtask

   task t_secure;
      bus(IMC_OFF_CTRL, 1'b1, 32'h1, 1'b0);
      chk(32'(r), 32'h2);
      rd(IMC_OFF_CTRL);
      chk(q, 32'h0);
      integ_sec_override <= 1'b1;
      bus(IMC_OFF_CTRL, 1'b1, 32'h1, 1'b0);
      chk(32'(r), 32'h0);
      chk(32'(integ_mode), 32'h1);
      wr(IMC_OFF_CTRL, 32'h0);
      integ_sec_override <= 1'b0;
   endtask

   task t_pins;
      func_out <= 32'h1234_abcd;
      dev_in <= 32'hc3c3_1e1e;
      wr(IMC_OFF_RDATA, 32'h5a5a_0f0f);
      @(negedge sys_clk);
      chk(dev_out, 32'h1234_abcd);
      chk(func_in, 32'hc3c3_1e1e);
      @(posedge sys_clk);
      wr(IMC_OFF_CTRL, 32'h1);
      @(negedge sys_clk);
      chk(dev_out, 32'h5a5a_0f0f);
      chk(func_in, 32'h0);
      @(posedge sys_clk);
      bus(IMC_OFF_RDATA, 1'b1, 32'hffff_ffff, 1'b0);
      chk(32'(r), 32'h2);
      @(negedge sys_clk);
      chk(dev_out, 32'h5a5a_0f0f);
      @(posedge sys_clk);
   endtask

   // one ram access, the far ram answered by the bench
   task ram_run(input logic [31:0] ctl, input logic [2:0] sel, input logic [31:0] idx, input logic [31:0] rv);
      int n;
      n = 0;
      wr(IMC_OFF_CTRL, ctl);
      wr(IMC_OFF_WDATA, ~idx);
      wr(IMC_OFF_INDEX, idx);
      @(negedge sys_clk);
      while (ram_req !== 1'b1 && n < 20) begin
         @(negedge sys_clk);
         n++;
      end
      chk(32'(ram_req), 32'h1);
      chk(32'(ram_we), 32'(ctl[2]));
      chk(32'(ram_target), 32'(ctl[3]));
      chk(32'(ram_select), 32'(sel));
      chk(ram_addr, idx);
      if (ctl[2]) chk(ram_wdata, ~idx);
      @(posedge sys_clk);
      ram_ack <= 1'b1;
      ram_rdata <= rv;
      @(posedge sys_clk);
      ram_ack <= 1'b0;
      ram_rdata <= ~rv;
      @(negedge sys_clk);
      chk(32'(ram_req), 32'h0);
      @(posedge sys_clk);
      n = 0;
      do begin
         rd(IMC_OFF_STATUS);
         n++;
      end while (q[0] !== 1'b0 && n < 20);
      chk(32'(q[0]), 32'h0);
      rd(IMC_OFF_RDATA);
      if (!ctl[2]) chk(q, rv);
   endtask

   task t_ram_walk;
      ram_run(32'h0000_01f7, 3'h1, 32'h0000_0123, 32'h0);
      ram_run(32'h0000_01e3, 3'h0, 32'h0000_00ff, 32'hdead_beef);
   endtask

   task t_ram_buffer;
      ram_run(32'h0000_005b, 3'h5, 32'h0000_0042, 32'h0bad_f00d);
      ram_run(32'h0000_01ff, 3'h7, 32'h8000_0001, 32'h0);
   endtask

   task t_drive_off;
      wr(IMC_OFF_CTRL, 32'h1);
      wr(IMC_OFF_INDEX, 32'h7);
      repeat (4) begin
         @(negedge sys_clk);
         chk(32'(ram_req), 32'h0);
      end
      @(posedge sys_clk);
   endtask

   task t_reset_again;
      rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      chk(32'(integ_mode), 32'h0);
      rd(IMC_OFF_CTRL);
      chk(q, 32'h0);
   endtask

   task conclude;
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // cuts a hang short
   initial begin
      repeat (20000) @(posedge sys_clk);
      failures++;
      conclude();
   end

   // main sequence
   initial begin
      failures = 0;
      n_tests = 0;
      rst = 1'b1;
      avs_address = 8'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hf;
      avs_secure = 1'b1;
      integ_sec_override = 1'b0;
      func_out = 32'h0;
      dev_in = 32'h0;
      ram_ack = 1'b0;
      ram_rdata = 32'h0;
      repeat (6) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      t_reset();
      t_secure();
      t_pins();
      t_ram_walk();
      t_ram_buffer();
      t_drive_off();
      t_reset_again();
      conclude();
   end
endmodule // tb_imc_top
